/* lplc_regs.vh */
// Constants for the LED PWM latch controller: latch layout, APB map, timing.
// Included by lplc_top.v; holds definitions only.
// Summary of operation
// - Twelve 16-bit grayscale fields, blue3 highest.
// - Red, green, blue 7-bit brightness fields.
// - Force-off bit blanks outputs, clears counter.
// - Force-off bit set at power-on.
// - Repeat bit reruns period every 65536 clocks.
// - Without repeat, run exactly one period.
// - Timing reset clears counter on latch pulse.
// - Without timing reset, latch pulse leaves counter.
// - Restart at next reference clock rising edge.
// - Clock-select bit picks oscillator or shift clock.
// - Edge-select bit picks rising or falling edge.
// - Latch pulse needs command 25h and 8x idle.
// - Idle timeout clamped to 8..16384 oscillator periods.
// - Repetition advances only while reference clock runs.
// - Latch pulse copies 218 low shift bits.
`ifndef LPLC_REGS_VH
`define LPLC_REGS_VH
`define LPLC_SR_W 224
`define LPLC_LAT_W 218
`define LPLC_GRAY_W 16
`define LPLC_CH_N 12
`define LPLC_BRT_W 7
`define LPLC_BRT_R_LSB 192
`define LPLC_BRT_G_LSB 199
`define LPLC_BRT_B_LSB 206
`define LPLC_BLANK 213
`define LPLC_RPT 214
`define LPLC_TRST_BIT 215
`define LPLC_EXTCK 216
`define LPLC_EDGE 217
`define LPLC_CMD_W 6
`define LPLC_WR_CMD 6'h25
`define LPLC_GRAY_LAST 16'hFFFF
`define LPLC_TO_SH 3
`define LPLC_MIN_SH 3
`define LPLC_MAX_SH 14
`define LPLC_CNT_W 27
`define LPLC_PER_W 24
`define LPLC_PER_MAX 24'hFFFFFF
`define LPLC_IDLE_MAX 27'h7FFFFFF
`define LPLC_IDLE_ONE 27'h0000001
`define LPLC_OSC_DIV_RST 8'h04
`define LPLC_ADDR_CTRL 8'h00
`define LPLC_ADDR_STAT 8'h04
`define LPLC_ADDR_LAT0 8'h10
`define LPLC_ADDR_LAT6 8'h28
`endif

/* lplc_top.v */
// LED PWM latch controller: serial shift register, latch pulse detector,
// 218-bit data latch, grayscale PWM engine and an APB status/control slave.
// Assumes pclk at 50 MHz; shift clock and data arrive asynchronously.
`include "lplc_regs.vh"
`default_nettype none
module lplc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire shift_clock_in,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg [11:0] led_sink_output,
  output reg [6:0] red_group_brightness,
  output reg [6:0] green_group_brightness,
  output reg [6:0] blue_group_brightness
);

  function [`LPLC_CNT_W-1:0] lplc_clamp;
    input [`LPLC_CNT_W-1:0] v;
    input [`LPLC_CNT_W-1:0] lo;
    input [`LPLC_CNT_W-1:0] hi;
    begin
      if (v < lo)
        lplc_clamp = lo;
      else if (v > hi)
        lplc_clamp = hi;
      else
        lplc_clamp = v;
    end
  endfunction

  // Period capture saturates instead of wrapping, so a long pause before a
  // packet only widens the bound for its first bit.
  function [`LPLC_PER_W-1:0] lplc_sat_period;
    input [`LPLC_CNT_W-1:0] v;
    begin
      if (v > {{(`LPLC_CNT_W-`LPLC_PER_W){1'b0}}, `LPLC_PER_MAX})
        lplc_sat_period = `LPLC_PER_MAX;
      else
        lplc_sat_period = v[`LPLC_PER_W-1:0];
    end
  endfunction

  reg sck_m_q;
  reg sck_s_q;
  reg sck_p_q;
  reg sdi_m_q;
  reg sdi_s_q;
  reg [`LPLC_SR_W-1:0] sr_q;
  reg [`LPLC_CNT_W-1:0] idle_q;
  reg [`LPLC_PER_W-1:0] period_q;
  reg armed_q;
  reg [7:0] osc_div_q;
  reg [7:0] osc_cnt_q;
  reg osc_lvl_q;
  reg ref_p_q;
  reg ext_p_q;
  reg [`LPLC_LAT_W-1:0] lat_q;
  reg [`LPLC_GRAY_W-1:0] gray_cnt_q;
  reg active_q;
  reg start_q;
  reg [11:0] on_d;
  reg [31:0] rd_d;
  reg map_d;
  integer ch;

  // Both pins pass two flops; the third stage only serves edge detection.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      sdi_m_q <= 1'b0;
      sdi_s_q <= 1'b0;
    end
    else
    begin
      sck_m_q <= shift_clock_in;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      sdi_m_q <= serial_data_in;
      sdi_s_q <= sdi_m_q;
    end
  end

  wire sck_rise = sck_s_q & ~sck_p_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_q <= {`LPLC_SR_W{1'b0}};
      serial_data_out <= 1'b0;
    end
    else
    begin
      if (sck_rise)
        sr_q <= {sr_q[`LPLC_SR_W-2:0], sdi_s_q};
      serial_data_out <= sr_q[`LPLC_SR_W-1];
    end
  end

  // The timeout follows the last shift period but is bounded by the
  // oscillator, so a stalled or very fast link still latches in time.
  wire [`LPLC_CNT_W-1:0] div_w = {{(`LPLC_CNT_W-8){1'b0}}, osc_div_q};
  wire [`LPLC_CNT_W-1:0] per_w = {{(`LPLC_CNT_W-`LPLC_PER_W){1'b0}}, period_q};
  wire [`LPLC_CNT_W-1:0] limit = lplc_clamp(per_w << `LPLC_TO_SH,
    div_w << `LPLC_MIN_SH, div_w << `LPLC_MAX_SH);
  wire cmd_ok = sr_q[`LPLC_SR_W-1 -: `LPLC_CMD_W] == `LPLC_WR_CMD;
  wire idle_done = armed_q & ~sck_rise & (idle_q >= limit);
  wire latch_pulse = idle_done & cmd_ok;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_q <= {`LPLC_CNT_W{1'b0}};
      period_q <= `LPLC_PER_MAX;
      armed_q <= 1'b0;
    end
    else if (sck_rise)
    begin
      // Counting from one makes idle_q the number of pclk periods since
      // the rise, so the captured period and the pause are both exact.
      idle_q <= `LPLC_IDLE_ONE;
      armed_q <= 1'b1;
      period_q <= lplc_sat_period(idle_q);
    end
    else
    begin
      if (idle_q != `LPLC_IDLE_MAX)
        idle_q <= idle_q + `LPLC_IDLE_ONE;
      if (idle_done)
        armed_q <= 1'b0;
    end
  end

  // The latch has no other writer, so brightness and mode bits only move
  // on a valid pulse.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat_q <= {`LPLC_LAT_W{1'b0}};
      lat_q[`LPLC_BLANK] <= 1'b1;
      red_group_brightness <= 7'h00;
      green_group_brightness <= 7'h00;
      blue_group_brightness <= 7'h00;
    end
    else if (latch_pulse)
    begin
      lat_q <= sr_q[`LPLC_LAT_W-1:0];
      red_group_brightness <= sr_q[`LPLC_BRT_R_LSB +: `LPLC_BRT_W];
      green_group_brightness <= sr_q[`LPLC_BRT_G_LSB +: `LPLC_BRT_W];
      blue_group_brightness <= sr_q[`LPLC_BRT_B_LSB +: `LPLC_BRT_W];
    end
  end

  wire blank = lat_q[`LPLC_BLANK];
  wire rpt_en = lat_q[`LPLC_RPT];
  wire ext_ck = lat_q[`LPLC_EXTCK];
  wire edge_sel = lat_q[`LPLC_EDGE];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_cnt_q <= 8'h00;
      osc_lvl_q <= 1'b0;
      ref_p_q <= 1'b0;
      ext_p_q <= 1'b0;
    end
    else
    begin
      if (osc_cnt_q + 8'h01 >= osc_div_q)
        osc_cnt_q <= 8'h00;
      else
        osc_cnt_q <= osc_cnt_q + 8'h01;
      osc_lvl_q <= osc_cnt_q < (osc_div_q >> 1);
      ref_p_q <= ext_ck ? sck_s_q : osc_lvl_q;
      ext_p_q <= ext_ck;
    end
  end

  wire ref_lvl = ext_ck ? sck_s_q : osc_lvl_q;
  // The cycle in which the source switches compares levels of two clocks;
  // it is masked so that the switch itself never counts as an edge.
  wire src_same = ext_ck == ext_p_q;
  wire ref_rise = src_same & ref_lvl & ~ref_p_q;
  wire ref_fall = src_same & ~ref_lvl & ref_p_q;
  wire out_edge = edge_sel ? ref_rise : ref_fall;
  wire tmg_reset = latch_pulse & sr_q[`LPLC_TRST_BIT];
  wire force_off = blank | tmg_reset;

  // A stopped reference clock gives no edges, so the counter simply holds.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gray_cnt_q <= 16'h0000;
      active_q <= 1'b0;
      start_q <= 1'b1;
    end
    else if (force_off)
    begin
      gray_cnt_q <= 16'h0000;
      active_q <= 1'b0;
      start_q <= 1'b1;
    end
    else if (ref_rise)
    begin
      if (start_q)
      begin
        active_q <= 1'b1;
        start_q <= 1'b0;
        gray_cnt_q <= 16'h0000;
      end
      else if (active_q)
      begin
        gray_cnt_q <= gray_cnt_q + 16'h0001;
        if (gray_cnt_q == `LPLC_GRAY_LAST)
          active_q <= rpt_en;
      end
    end
  end

  always @*
  begin
    on_d = 12'h000;
    for (ch = 0; ch < `LPLC_CH_N; ch = ch + 1)
      on_d[ch] = active_q & (gray_cnt_q < lat_q[ch*`LPLC_GRAY_W +: `LPLC_GRAY_W]);
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_sink_output <= 12'h000;
    else if (force_off)
      led_sink_output <= 12'h000;
    else if (out_edge)
      led_sink_output <= on_d;
  end

  wire [`LPLC_SR_W-1:0] lat_pad = {{(`LPLC_SR_W-`LPLC_LAT_W){1'b0}}, lat_q};
  wire [7:0] lat_off = paddr - `LPLC_ADDR_LAT0;

  always @*
  begin
    rd_d = 32'h00000000;
    map_d = 1'b1;
    if (paddr == `LPLC_ADDR_CTRL)
      rd_d = {24'h000000, osc_div_q};
    else if (paddr == `LPLC_ADDR_STAT)
      rd_d = {8'h00, cmd_ok, lat_q[`LPLC_EDGE:`LPLC_BLANK], start_q, active_q,
        gray_cnt_q};
    else if (paddr >= `LPLC_ADDR_LAT0 && paddr <= `LPLC_ADDR_LAT6 &&
      paddr[1:0] == 2'h0)
      rd_d = lat_pad[lat_off[4:2]*32 +: 32];
    else
      map_d = 1'b0;
  end

  // Zero wait states: the answer is staged in the setup cycle so that the
  // access cycle completes at once.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      osc_div_q <= `LPLC_OSC_DIV_RST;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel & ~penable)
      begin
        pslverr <= ~map_d;
        prdata <= pwrite ? 32'h00000000 : rd_d;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
      if (psel & penable & pready & pwrite && paddr == `LPLC_ADDR_CTRL)
        osc_div_q <= pwdata[7:0];
    end
  end

endmodule
`default_nettype wire

/* lplc_monitor.sv */
// Port checks for lplc_top: APB handshake, reset state and latch pacing.
// Bound to lplc_top; pclk rising edge, presetn active low.
`default_nettype none
module lplc_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic shift_clock_in,
  input wire logic [11:0] led_sink_output,
  input wire logic [6:0] red_group_brightness
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] idle_q;
  // Counts pclk periods since the last shift clock rise; saturates so that a
  // long pause never wraps back under the bound.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      idle_q <= 8'h00;
    else
      idle_q <= $rose(shift_clock_in) ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
  rdy_after_setup_a: assert property (psel && !penable |=> pready) else $error("no ready");
  rdy_one_cycle_a: assert property (pready |=> !pready) else $error("long ready");
  rdy_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_no_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error");
  data_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  reset_leds_off_a: assert property
    ($rose(presetn) |-> led_sink_output == 12'h000) else $error("leds on");
  latch_after_pause_a: assert property
    ($changed(red_group_brightness) |-> idle_q >= 8'h40) else $error("early latch");
  latch_once_a: assert property
    ($changed(red_group_brightness) |=> $stable(red_group_brightness) [*8])
    else $error("relatch");
  cover property (pslverr);
  cover property ($changed(red_group_brightness));
  cover property (led_sink_output != 12'h000);
endmodule
bind lplc_top lplc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shift_clock_in(shift_clock_in), .led_sink_output(led_sink_output),
  .red_group_brightness(red_group_brightness));
`default_nettype wire

/* lplc_shifter.sv */
// Far-side controller: shifts packets MSB first, then pauses the clock.
// Runs from pclk; the shift clock period is 8 pclk, 160 ns.
`default_nettype none
module lplc_shifter (
  input wire logic pclk,
  output var logic sck = 1'b0,
  output var logic sdi = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic send(input logic [223:0] p);
    @(posedge pclk);
    for (int i = 223; i >= 0; i--)
    begin
      sck <= 1'b0;
      sdi <= p[i];
      repeat (4) @(posedge pclk);
      sck <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    sck <= 1'b0;
    // Inverting the idle data line keeps stale bits from passing as valid.
    sdi <= ~p[0];
    repeat (100) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* led_pwm_latch_control_test.sv */
// Bench for lplc_top: packets and APB reads checked against a latch model.
// Assumes lplc_shifter as the far-side controller.
`default_nettype none
module led_pwm_latch_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, s = 32'h0001358B;
  logic pready, pslverr, err, sck, sdi, sdo, run;
  logic sr_top = 1'b0;
  logic [11:0] led, on;
  logic [6:0] brt_r, brt_g, brt_b;
  logic [223:0] ml = 224'h0, pk;
  logic [4:0] fnc [5] = '{5'h12, 5'h12, 5'h01, 5'h0C, 5'h06};
  int num_errors = 0, cmp_count = 0;
  always #10 pclk = ~pclk;
  lplc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shift_clock_in(sck), .serial_data_in(sdi), .serial_data_out(sdo),
    .led_sink_output(led), .red_group_brightness(brt_r), .green_group_brightness(brt_g),
    .blue_group_brightness(brt_b));
  lplc_shifter sh (.pclk(pclk), .sck(sck), .sdi(sdi));
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp_all();
    run = !ml[213] && !ml[216];
    for (int i = 0; i < 12; i++)
      on[i] = run && ml[16*i +: 16] != 16'h0000;
    chk(32'(led), 32'(on));
    chk(32'({brt_b, brt_g, brt_r}), 32'(ml[212:192]));
    chk(32'(sdo), 32'(sr_top));
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
      chk(rd, ml[32*i +: 32]);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk({rd[22:18], run ? 16'h0 : rd[15:0]}, {ml[217:213], 16'h0});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #600000;
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    ml[213] = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cmp_all();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000004);
    apb(1'b1, 8'h00, 32'h00000002);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000002);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(err), 32'h00000001);
    chk(rd, 32'h00000000);
    for (int k = 0; k < 5; k++)
    begin
      for (int i = 0; i < 12; i++)
        pk[16*i +: 16] = rnd() & 32'h1 ? 16'hFFFF : 16'h0000;
      pk[223:192] = {k == 1 ? 6'h2A : 6'h25, fnc[k], 21'(rnd())};
      sh.send(pk);
      sr_top = pk[223];
      if (k != 1)
        ml[217:0] = pk[217:0];
      cmp_all();
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
